// file: seep_bus_master.sv
// Two-wire bus master model that drives the serial clock and data
`timescale 1ns/1ps
module seep_bus_master (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_m
);
    // Both lines idle released high
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // One quarter bit: change just after an edge, then hold four clocks
    task automatic ph(input logic c, input logic d);
        scl   = c;
        sda_m = d;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Data moves only with the clock low; the wire is read mid high phase
    task automatic bit_io(input logic b, output logic s);
        ph(1'b0, b);
        ph(1'b1, b);
        s = sda_line;
        ph(1'b1, b);
        ph(1'b0, b);
    endtask
    // Also serves as repeated Start
    task automatic start();
        ph(scl, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // Address and data go out MSB first; the ninth slot is left to the slave
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, s);
    endtask
endmodule

// file: seep_page_buf.sv
// Page buffer with per-byte written flags
`timescale 1ns/1ps
module seep_page_buf #(
    parameter int DEPTH = seep_pkg::PAGE_BYTES,
    parameter int IDX_W = seep_pkg::PAGE_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [7:0]       wr_data,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [7:0]       rd_data,
    output logic                  rd_valid
);
    logic [7:0]       mem_reg [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [DEPTH-1:0] valid_next;

    // Later byte to the same slot overwrites the earlier one
    always_comb begin
        valid_next = valid_reg;
        if (clear) begin
            valid_next = '0;
        end
        if (wr_en) begin
            valid_next[wr_idx] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            valid_reg <= '0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // Data array carries no reset, only the flags do
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_idx] <= wr_data;
        end
    end

    assign rd_data  = mem_reg[rd_idx];
    assign rd_valid = valid_reg[rd_idx];
endmodule

// file: seep_pkg.sv
// Shared constants and carrier types for the two-wire serial EEPROM slave
package seep_pkg;
    localparam int          ADDR_W        = 17;
    localparam int          PAGE_BYTES    = 128;
    localparam int          PAGE_W        = 7;
    localparam logic [3:0]  DEV_TYPE_CODE = 4'hA;
    localparam int          WRITE_CYCLES  = 200;
    localparam int          CTL_DIR_BIT   = 0;
    localparam int          CTL_CSL_BIT   = 1;
    localparam int          CTL_CSH_BIT   = 2;
    localparam int          CTL_HALF_BIT  = 3;
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [3:0]  BIT_ACK       = 4'h8;

    // One storage-side request
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [ADDR_W-1:0]    addr;
        logic [7:0]           data;
    } seep_mem_req_t;
endpackage

// file: seep_slave.sv
// Two-wire serial EEPROM slave: command decode, page write, reads
`timescale 1ns/1ps
module seep_slave #(
    parameter int WRITE_CYCLES = seep_pkg::WRITE_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe_n,
    input  wire logic                        chip_sel_low_pin,
    input  wire logic                        chip_sel_high_pin,
    input  wire logic                        wp_in,
    output seep_pkg::seep_mem_req_t          mem_req,
    input  wire logic [7:0]                  mem_rdata,
    output logic                             busy
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum {SEEP_IDLE, SEEP_CTRL, SEEP_ADRH, SEEP_ADRL, SEEP_WDATA,
                  SEEP_RDATA, SEEP_RACK, SEEP_FETCH, SEEP_FILL,
                  SEEP_COMMIT} seep_state_t;

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    seep_state_t   state_reg, state_next;
    logic          scl_d_reg, sda_d_reg;
    logic [3:0]    bit_reg, bit_next;
    logic [7:0]    sh_reg, sh_next;
    logic [16:0]   ptr_reg, ptr_next;
    logic [7:0]    ctl_reg, ctl_next;
    logic [6:0]    wctl_reg, wctl_next;
    logic          drive_reg, drive_next;
    logic          obit_reg, obit_next;
    logic          busy_reg, busy_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [7:0]    cidx_reg, cidx_next;
    logic          wdata_seen_reg, wdata_seen_next;
    logic [6:0]    pb_wr_idx;
    logic [7:0]    pb_wr_data;
    seep_pkg::seep_mem_req_t req_reg, req_next;
    logic          pb_clear, pb_wr;
    logic [6:0]    pb_rd_idx;
    logic [7:0]    pb_rd_data;
    logic          pb_rd_valid;

    // Bus conditions seen on the live pins against their registered copies
    wire scl_rise = scl_in & ~scl_d_reg;
    wire scl_fall = ~scl_in & scl_d_reg;
    wire start_c  = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    wire stop_c   = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
    wire [7:0] rx_byte = {sh_reg[6:0], sda_in};
    // Control byte is whole in the shifter at the eighth SCL fall
    wire ctl_ok = (sh_reg[7:4] == seep_pkg::DEV_TYPE_CODE)
                & (sh_reg[seep_pkg::CTL_CSL_BIT] == chip_sel_low_pin)
                & (sh_reg[seep_pkg::CTL_CSH_BIT] == chip_sel_high_pin);
    // Busy refuses only control bytes for the half being written, reads or writes
    wire busy_block = busy_reg & (sh_reg[7:1] == wctl_reg);
    // Bus is ignored while the page walk owns the storage port
    wire walking = (state_reg == SEEP_FILL) | (state_reg == SEEP_COMMIT);
    // Sequential step keeps the half bit, wrapping within 64K
    wire [16:0] ptr_inc = {ptr_reg[16], ptr_reg[15:0] + 16'h0001};

    seep_page_buf #(
        .DEPTH (seep_pkg::PAGE_BYTES),
        .IDX_W (seep_pkg::PAGE_W)
    ) u_page_buf (
        .clk      (clk),
        .reset_n  (reset_n),
        .clear    (pb_clear),
        .wr_en    (pb_wr),
        .wr_idx   (pb_wr_idx),
        .wr_data  (pb_wr_data),
        .rd_idx   (pb_rd_idx),
        .rd_data  (pb_rd_data),
        .rd_valid (pb_rd_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Protocol and write-cycle next-state logic
    always_comb begin
        state_next      = state_reg;
        bit_next        = bit_reg;
        sh_next         = sh_reg;
        ptr_next        = ptr_reg;
        ctl_next        = ctl_reg;
        wctl_next       = wctl_reg;
        drive_next      = drive_reg;
        obit_next       = obit_reg;
        busy_next       = busy_reg;
        cnt_next        = cnt_reg;
        cidx_next       = cidx_reg;
        wdata_seen_next = wdata_seen_reg;
        req_next        = '0;
        pb_clear        = 1'b0;
        pb_wr           = 1'b0;
        pb_wr_idx       = ptr_reg[6:0];
        pb_wr_data      = sh_reg;
        pb_rd_idx       = cidx_reg[6:0];

        // Fill pass: storage answers a cycle after its address, so old bytes
        // land in the buffer slots left unwritten before the walk begins
        if (state_reg == SEEP_FILL) begin
            pb_rd_idx  = cidx_reg[6:0] - 7'h01;
            pb_wr_idx  = cidx_reg[6:0] - 7'h01;
            pb_wr_data = mem_rdata;
            pb_wr      = (cidx_reg != 8'h00) && !pb_rd_valid;
            cidx_next  = cidx_reg + 8'h01;
            if (cidx_reg[7]) begin
                cidx_next  = 8'h00;
                state_next = SEEP_COMMIT;
            end else begin
                req_next.rd   = 1'b1;
                req_next.addr = {ptr_reg[16:7], cidx_reg[6:0]};
            end
        end
        // Write cycle walks the whole page from the filled buffer
        if (state_reg == SEEP_COMMIT) begin
            req_next.wr   = 1'b1;
            req_next.addr = {ptr_reg[16:7], cidx_reg[6:0]};
            req_next.data = pb_rd_data;
            cidx_next     = cidx_reg + 8'h01;
            if (cidx_reg[6:0] == 7'h7F) begin
                state_next = SEEP_IDLE;
                pb_clear   = 1'b1;
            end
        end
        // Busy lasts the set count from Stop, longer only if the walk is
        if (busy_reg) begin
            if (cnt_reg != CNT_W'(WRITE_CYCLES - 1)) begin
                cnt_next = cnt_reg + CNT_W'(1);
            end else if (!walking) begin
                busy_next = 1'b0;
            end
        end

        if (!walking) begin
            if (start_c) begin
                state_next    = SEEP_CTRL;
                bit_next      = 4'hF;       // Start's own SCL fall wraps to 0
                drive_next    = 1'b0;
                if (wdata_seen_reg) begin
                    pb_clear        = 1'b1;
                    wdata_seen_next = 1'b0;
                end
            end else if (stop_c) begin
                state_next = SEEP_IDLE;
                drive_next = 1'b0;
                if (wdata_seen_reg) begin
                    wdata_seen_next = 1'b0;
                    if (wp_in) begin
                        pb_clear = 1'b1;
                    end else begin
                        wctl_next  = ctl_reg[7:1];
                        busy_next  = 1'b1;
                        cnt_next   = '0;
                        cidx_next  = 8'h00;
                        state_next = SEEP_FILL;
                    end
                end
            end else if (scl_rise && state_reg != SEEP_IDLE) begin
                // While sending, the shifter holds outgoing bits; no sampling
                if (bit_reg <= seep_pkg::BIT_LAST && state_reg != SEEP_RDATA) begin
                    sh_next = rx_byte;
                end
                // Master nack ends the read; an ack fetches on the SCL fall
                if (state_reg == SEEP_RACK && bit_reg == seep_pkg::BIT_ACK && sda_in) begin
                    state_next = SEEP_IDLE;
                end
            end else if (scl_fall && state_reg != SEEP_IDLE) begin
                bit_next   = bit_reg + 4'h1;
                drive_next = 1'b0;
                if (bit_reg == seep_pkg::BIT_LAST) begin
                    case (state_reg)
                        SEEP_CTRL: begin
                            if (ctl_ok && !busy_block) begin
                                ctl_next      = sh_reg;
                                drive_next    = 1'b1;
                                obit_next     = 1'b0;
                                ptr_next[16]  = sh_reg[seep_pkg::CTL_HALF_BIT];
                            end else begin
                                state_next = SEEP_IDLE;
                            end
                        end
                        SEEP_ADRH: begin
                            ptr_next[15:8] = sh_reg;
                            drive_next     = 1'b1;
                            obit_next      = 1'b0;
                        end
                        SEEP_ADRL: begin
                            ptr_next[7:0] = sh_reg;
                            drive_next    = 1'b1;
                            obit_next     = 1'b0;
                        end
                        SEEP_WDATA: begin
                            pb_wr           = 1'b1;
                            wdata_seen_next = 1'b1;
                            ptr_next[6:0]   = ptr_reg[6:0] + 7'h01;
                            drive_next      = 1'b1;
                            obit_next       = 1'b0;
                        end
                        SEEP_RDATA: begin
                            state_next = SEEP_RACK;
                            ptr_next   = ptr_inc;
                        end
                        default: begin
                            state_next = state_reg;
                        end
                    endcase
                end else if (bit_reg == seep_pkg::BIT_ACK) begin
                    bit_next = 4'h0;
                    case (state_reg)
                        SEEP_CTRL: begin
                            if (ctl_reg[seep_pkg::CTL_DIR_BIT]) begin
                                state_next = SEEP_FETCH;
                            end else begin
                                state_next = SEEP_ADRH;
                            end
                        end
                        SEEP_ADRH:  state_next = SEEP_ADRL;
                        SEEP_ADRL:  state_next = SEEP_WDATA;
                        SEEP_WDATA: state_next = SEEP_WDATA;
                        SEEP_RACK:  state_next = SEEP_FETCH;
                        default:    state_next = state_reg;
                    endcase
                end else if (state_reg == SEEP_RDATA) begin
                    drive_next = ~sh_reg[7];
                    obit_next  = 1'b0;
                    sh_next    = {sh_reg[6:0], 1'b1};
                end
            end

            // Load the byte and put its first bit out while SCL is low
            if (state_reg == SEEP_FETCH && !start_c && !stop_c) begin
                sh_next    = {mem_rdata[6:0], 1'b1};
                drive_next = ~mem_rdata[7];
                obit_next  = 1'b0;
                bit_next   = 4'h0;
                state_next = SEEP_RDATA;
            end
        end
        if (state_next == SEEP_FETCH) begin
            req_next.rd   = 1'b1;
            req_next.addr = ptr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg      <= SEEP_IDLE;
            scl_d_reg      <= 1'b1;
            sda_d_reg      <= 1'b1;
            bit_reg        <= 4'h0;
            sh_reg         <= 8'h00;
            ptr_reg        <= 17'h00000;
            ctl_reg        <= 8'h00;
            wctl_reg       <= 7'h00;
            drive_reg      <= 1'b0;
            obit_reg       <= 1'b0;
            busy_reg       <= 1'b0;
            cnt_reg        <= '0;
            cidx_reg       <= 8'h00;
            wdata_seen_reg <= 1'b0;
            req_reg        <= '0;
        end else begin
            state_reg      <= state_next;
            scl_d_reg      <= scl_in;
            sda_d_reg      <= sda_in;
            bit_reg        <= bit_next;
            sh_reg         <= sh_next;
            ptr_reg        <= ptr_next;
            ctl_reg        <= ctl_next;
            wctl_reg       <= wctl_next;
            drive_reg      <= drive_next;
            obit_reg       <= obit_next;
            busy_reg       <= busy_next;
            cnt_reg        <= cnt_next;
            cidx_reg       <= cidx_next;
            wdata_seen_reg <= wdata_seen_next;
            req_reg        <= req_next;
        end
    end

    // Open-drain: only ever pull low, released means high
    assign sda_out  = obit_reg;
    assign sda_oe_n = ~drive_reg;
    assign mem_req  = req_reg;
    assign busy     = busy_reg;
endmodule

// file: seep_sva.sv
// Concurrent checks on the ports of the two-wire EEPROM slave
`timescale 1ns/1ps
module seep_sva #(
    parameter int WRITE_CYCLES = seep_pkg::WRITE_CYCLES
) (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    scl_in,
    input wire logic                    sda_in,
    input wire logic                    sda_out,
    input wire logic                    sda_oe_n,
    input wire logic                    chip_sel_low_pin,
    input wire logic                    chip_sel_high_pin,
    input wire logic                    wp_in,
    input wire seep_pkg::seep_mem_req_t mem_req,
    input wire logic [7:0]              mem_rdata,
    input wire logic                    busy
);
    logic        sda_reg, sda_next;
    logic [9:0]  since_reg, since_next;
    logic [7:0]  run_reg, run_next;
    logic [15:0] bcnt_reg, bcnt_next;
    ////////////////////////////////////////////////////////////////
    // Cycles since Stop saturate, so a long idle never looks like a fresh Stop
    always_comb begin
        sda_next   = sda_in;
        since_next = (scl_in && sda_in && !sda_reg) ? 10'h000 : since_reg + 10'(since_reg != 10'h3FF);
        run_next   = mem_req.wr ? run_reg + 8'h01 : 8'h00;
        bcnt_next  = busy ? bcnt_reg + 16'h0001 : 16'h0000;
    end
    // Run lengths clear themselves once write pulses and busy drop in reset
    always_ff @(posedge clk) begin
        sda_reg   <= sda_next;
        since_reg <= reset_n ? since_next : 10'h3FF;
        run_reg   <= run_next;
        bcnt_reg  <= bcnt_next;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    sequence s_quiet;
        (!busy && !mem_req.wr)[*8];
    endsequence
    AST_RESET_IDLE: assert property (disable iff (1'b0) // RESET
        !reset_n |=> sda_oe_n && !busy && !mem_req.wr) else $error("outputs not idle in reset");
    AST_OE_STABLE_HIGH: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_n)) else $error("data moved with clock high");
    AST_COMMIT_AFTER_STOP: assert property (
        $rose(mem_req.wr) |-> since_reg <= 10'h090) else $error("commit not led by Stop");
    AST_WALK_LEN: assert property (
        $fell(mem_req.wr) |-> run_reg == 8'h80) else $error("commit walk not a full page");
    AST_WALK_PAGE: assert property (
        mem_req.wr && $past(mem_req.wr) |-> mem_req.addr[16:7] == $past(mem_req.addr[16:7])
        && mem_req.addr[6:0] == $past(mem_req.addr[6:0]) + 7'h01) else $error("walk left page");
    AST_BUSY_AFTER_STOP: assert property (
        $rose(busy) |-> since_reg <= 10'h0A0) else $error("busy without a Stop");
    AST_WP_QUIET: assert property (
        s_stop ##0 (wp_in && !busy) |=> s_quiet) else $error("protected write started a cycle");
    AST_BUSY_LEN: assert property (
        $fell(busy) |-> bcnt_reg >= WRITE_CYCLES - 1 && bcnt_reg <= WRITE_CYCLES + 1)
        else $error("busy length off");
endmodule

bind seep_slave seep_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_seep_sva (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chip_sel_low_pin(chip_sel_low_pin),
    .chip_sel_high_pin(chip_sel_high_pin), .wp_in(wp_in), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .busy(busy));

// file: test_serial_eeprom_two_wire_slave.sv
// Bench for the two-wire EEPROM slave with a storage model and bus master
`timescale 1ns/1ps
module test_serial_eeprom_two_wire_slave;
    logic                    clk, reset_n, scl, sda_m, sda_line, sda_out, sda_oe_n, wp, busy;
    logic [1:0]              pins;
    logic [7:0]              mem_rdata;
    logic [7:0]              mem [0:131071];
    logic [7:0]              exp_mem [0:131071];
    seep_pkg::seep_mem_req_t mem_req;
    int                      mismatches, comparisons, wr_count, tnum;
    ////////////////////////////////////////////////////////////////
    // Pulled-up data line: low when either side pulls it down
    assign sda_line  = sda_m & (sda_oe_n | sda_out);
    assign mem_rdata = mem[mem_req.addr];
    // Storage commits each write pulse and counts them
    always @(posedge clk) begin
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.data;
            wr_count <= wr_count + 1;
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    seep_slave #(.WRITE_CYCLES(400)) i_seep_slave (
        .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .chip_sel_low_pin(pins[0]), .chip_sel_high_pin(pins[1]),
        .wp_in(wp), .mem_req(mem_req), .mem_rdata(mem_rdata), .busy(busy));
    seep_bus_master i_seep_bus_master (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] e, input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [7:0] ctl(input logic half, input logic rd);
        return {seep_pkg::DEV_TYPE_CODE, half, pins, rd};
    endfunction
    // Address k bytes on, inside the page or inside the 64K half
    function automatic logic [16:0] pg(input logic [16:0] a, input int k, input logic sq);
        return sq ? {a[16], 16'(a[15:0] + k)} : {a[16:7], 7'(a[6:0] + k)};
    endfunction
    task automatic snd(input logic [7:0] b, input logic e);
        logic a;
        i_seep_bus_master.send_byte(b, a);
        chk({16'h0000, e}, {16'h0000, a});
    endtask
    // Poll until acknowledged; a cycle under way must refuse the first try
    task automatic poll(input logic half, input logic busy_exp);
        logic a;
        int   tries;
        a = 1'b0;
        tries = 0;
        while (!a && tries < 40) begin
            i_seep_bus_master.start();
            i_seep_bus_master.send_byte(ctl(half, 1'b0), a);
            tries++;
        end
        i_seep_bus_master.stop();
        chk(17'h00001, {16'h0000, a});
        if (!a) close_out();
        chk({16'h0000, busy_exp}, {16'h0000, tries > 1});
    endtask
    task automatic wr_op(input logic [16:0] a, input int n, input logic wp0, input logic wp1);
        logic [7:0] d;
        wp = wp0;
        wr_count = 0;
        i_seep_bus_master.start();
        snd(ctl(a[16], 1'b0), 1'b1);
        snd(a[15:8], 1'b1);
        snd(a[7:0], 1'b1);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            snd(d, 1'b1);
            if (!wp0) exp_mem[pg(a, k, 1'b0)] = d;
        end
        i_seep_bus_master.stop();
        repeat (8) @(posedge clk);
        #1 wp = wp1;
        poll(a[16], !wp0);
        chk(wp0 ? 17'h00000 : 17'h00080, 17'(wr_count));
        for (int k = 0; k < 128; k++) chk(exp_mem[pg(a, k, 1'b0)], mem[pg(a, k, 1'b0)]);
    endtask
    // Random read when rnd is set, otherwise a current-address read
    task automatic rd_op(input logic [16:0] a, input int n, input logic rnd);
        logic [7:0] d;
        if (rnd) begin
            i_seep_bus_master.start();
            snd(ctl(a[16], 1'b0), 1'b1);
            snd(a[15:8], 1'b1);
            snd(a[7:0], 1'b1);
        end
        i_seep_bus_master.start();
        snd(ctl(a[16], 1'b1), 1'b1);
        for (int k = 0; k < n; k++) begin
            i_seep_bus_master.recv_byte(k < n - 1, d);
            chk(exp_mem[pg(a, k, 1'b1)], d);
        end
        chk(17'h00001, {16'h0000, sda_oe_n});
        i_seep_bus_master.stop();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [16:0] a;
        logic [7:0]  c;
        reset_n = 1'b0;
        wp = 1'b0;
        pins = 2'h0;
        mismatches = 0;
        comparisons = 0;
        wr_count = 0;
        for (int i = 0; i < 131072; i++) begin
            mem[i] = 8'(i ^ (i >> 8));
            exp_mem[i] = 8'(i ^ (i >> 8));
        end
        void'($urandom(32'h3FDB4C76));
        pins = 2'($urandom);
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (2) @(posedge clk);
        // Only the right type code and chip bits draw an acknowledge
        for (int i = 0; i < 8; i++) begin
            c = {i < 4 ? seep_pkg::DEV_TYPE_CODE : 4'hB, 1'b0, 2'(i), 1'b0};
            i_seep_bus_master.start();
            snd(c, i < 4 && 2'(i) == pins);
            i_seep_bus_master.stop();
        end
        $display("test 1 done");
        // Byte write away from the page end, then a current-address read
        a = 17'($urandom);
        a[6:0] = 7'($urandom_range(126, 0));
        wr_op(a, 1, 1'b0, 1'b0);
        rd_op(pg(a, 1, 1'b0), 1, 1'b0);
        // Page writes that wrap at the page end and overrun the buffer
        for (int j = 0; j < 2; j++) begin
            a = 17'($urandom);
            if (j == 0) a[6:0] = 7'h7E;
            wr_op(a, j ? 130 : 4, 1'b0, 1'b0);
        end
        // Protected writes in both halves, then protect raised after Stop
        for (int j = 0; j < 2; j++) wr_op({1'(j), 16'($urandom)}, 3, 1'b1, 1'b1);
        wr_op(17'($urandom), 2, 1'b0, 1'b1);
        wp = 1'b0;
        $display("test 2 done");
        // Sequential reads wrap inside each half; pointer follows the last byte
        rd_op(17'h0FFFE, 4, 1'b1);
        rd_op(17'h00002, 1, 1'b0);
        rd_op(17'h1FFFD, 5, 1'b1);
        rd_op(17'h10002, 1, 1'b0);
        rd_op(17'($urandom), 1 + $urandom_range(3, 0), 1'b1);
        $display("test 3 done");
        close_out();
    end
endmodule
